//--- hdl/vdp_core.sv
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Fetch one eight-slot 256-bit packet as the previous packet's last slot issues
// - Lowest bit chains slots into execute packets
// - Two files, sixteen 32-bit entries each
// - Predicates only from A1, A2, B0-B2
// - Eight units: logic, shift, multiply, address
// - One 32-bit instruction per unit per issue
// - Only address units touch data memory
// - One cross read per side per cycle
// - No dependency checks, no stalls
// - Operands and results live in registers
// - One control file, reached only by the two S units
// - Byte, half, word data; 40-bit add
// - Each unit writes only its own file
module vdp_core
   import vdp_pkg::*;
(
   // Clock and reset
   input  wire logic                  mclk,
   input  wire logic                  rstn,
   // Program memory
   output logic                       fetch_req,
   output logic [31:0]                fetch_addr,
   input  wire logic                  fetch_valid,
   input  wire logic [FP_W-1:0]       fetch_packet,
   // Data memory, index 0 file A, index 1 file B
   output logic [1:0]                 dm_req,
   output logic [1:0]                 dm_we,
   output logic [1:0][31:0]           dm_addr,
   output logic [1:0][31:0]           dm_wdata,
   output logic [1:0][3:0]            dm_be,
   input  wire logic [1:0][31:0]      dm_rdata,
   // Status
   output logic [SLOTS-1:0]           issue_mask
);

   vdp_fst_t                     fs, next_fs;
   logic [FP_W-1:0]              pkt, next_pkt;
   logic [2:0]                   ptr, next_ptr;
   logic [31:0]                  pc, next_pc;
   logic [SLOTS-1:0]             ep_mask;
   logic [2:0]                   ep_last;
   logic                         take;
   logic [1:0][NREG-1:0][DW-1:0] qf;
   logic [1:0][NWP-1:0]          we;
   logic [1:0][NWP-1:0][RA_W-1:0] wa;
   logic [1:0][NWP-1:0][DW-1:0]  wd;
   logic [7:0]                   uv;
   logic [7:0][IW-1:0]           ui;
   logic [1:0][DW-1:0]           xbus;
   logic [1:0][RA_W-1:0]         xaddr;
   logic [NCTL-1:0][DW-1:0]      ctl, next_ctl;
   logic [1:0]                   next_dm_req, next_dm_we;
   logic [1:0][31:0]             next_dm_addr, next_dm_wdata;
   logic [1:0][3:0]              next_dm_be;
   vdp_ld_t [1:0]                ld1, next_ld1, ld2;

   function automatic logic pred_ok(input logic [2:0] cr, input logic z,
                                    input logic [NREG-1:0][DW-1:0] fa,
                                    input logic [NREG-1:0][DW-1:0] fb);
      logic nz;
      nz = 1'b0;
      case (cr)
         CR_NONE: return 1'b1;
         CR_B0:   nz = |fb[0];
         CR_B1:   nz = |fb[1];
         CR_B2:   nz = |fb[2];
         CR_A1:   nz = |fa[1];
         CR_A2:   nz = |fa[2];
         default: return 1'b0;
      endcase
      return z ? !nz : nz;
   endfunction : pred_ok

   function automatic logic [3:0] mem_be(input logic [1:0] sz,
                                         input logic [1:0] lane);
      case (sz)
         SZ_H:    return lane[1] ? 4'hc : 4'h3;
         SZ_B:    return 4'(4'h1 << lane);
         default: return 4'hf;
      endcase
   endfunction : mem_be

   function automatic logic [31:0] ld_extract(input logic [31:0] r,
                                              input logic [1:0] sz,
                                              input logic [1:0] lane);
      logic [15:0] h;
      logic [7:0]  b;
      h = lane[1] ? r[31:16] : r[15:0];
      b = r[{lane, 3'h0} +: 8];
      case (sz)
         SZ_H:    return {{16{h[15]}}, h};
         SZ_B:    return {{24{b[7]}}, b};
         default: return r;
      endcase
   endfunction : ld_extract

   vdp_rf_if rf_a ();
   vdp_rf_if rf_b ();

   vdp_regfile u_file_a (.mclk(mclk), .rstn(rstn), .rf(rf_a.file));
   vdp_regfile u_file_b (.mclk(mclk), .rstn(rstn), .rf(rf_b.file));

   assign qf[0]   = rf_a.q;
   assign qf[1]   = rf_b.q;
   assign rf_a.we = we[0];
   assign rf_a.wa = wa[0];
   assign rf_a.wd = wd[0];
   assign rf_b.we = we[1];
   assign rf_b.wa = wa[1];
   assign rf_b.wd = wd[1];

   // Chain ends at a clear low bit or at the last slot
   always_comb begin
      logic open;
      open    = 1'b1;
      ep_mask = '0;
      ep_last = LAST_SLOT;
      for (int i = 0; i < SLOTS; i++) begin
         if (i >= int'(ptr) && open) begin
            ep_mask[i] = 1'b1;
            if (!pkt[i*IW+P_BIT]) begin
               open    = 1'b0;
               ep_last = 3'(i);
            end
         end
      end
      if (fs != FS_HOLD) begin
         ep_mask = '0;
         ep_last = LAST_SLOT;
      end
   end

   // Next packet requested while the last one drains, so no bubble
   assign fetch_req = (fs == FS_IDLE) || (ep_last == LAST_SLOT);
   assign take      = fetch_req && fetch_valid;

   always_comb begin
      next_fs  = fs;
      next_pkt = pkt;
      next_ptr = ptr;
      next_pc  = pc;
      case (fs)
         FS_IDLE: begin
            if (take) begin
               next_fs  = FS_HOLD;
               next_pkt = fetch_packet;
               next_ptr = 3'h0;
               next_pc  = pc + FETCH_STEP;
            end
         end
         FS_HOLD: begin
            if (take) begin
               next_pkt = fetch_packet;
               next_ptr = 3'h0;
               next_pc  = pc + FETCH_STEP;
            end else if (ep_last == LAST_SLOT) begin
               next_fs = FS_IDLE;
            end else begin
               next_ptr = ep_last + 3'h1;
            end
         end
         default: next_fs = FS_IDLE;
      endcase
   end

   // Route each issued slot to the unit its field names
   always_comb begin
      logic [2:0] u;
      u  = 3'h0;
      uv = '0;
      ui = '0;
      for (int i = 0; i < SLOTS; i++) begin
         if (ep_mask[i]) begin
            u     = pkt[i*IW+UNIT_LO +: 3];
            uv[u] = 1'b1;
            ui[u] = pkt[i*IW +: IW];
         end
      end
   end

   // First cross user on a side owns the bus; others share its value
   always_comb begin
      logic found;
      logic [2:0] u;
      found = 1'b0;
      u     = 3'h0;
      xaddr = '0;
      for (int s = 0; s < 2; s++) begin
         found = 1'b0;
         for (int c = 0; c < 3; c++) begin
            u = {1'(s), 2'(c)};
            if (uv[u] && ui[u][X_BIT] && !found) begin
               found    = 1'b1;
               xaddr[s] = ui[u][SRC2_LO +: RA_W];
            end
         end
      end
      xbus[0] = qf[1][xaddr[0]];
      xbus[1] = qf[0][xaddr[1]];
   end

   always_comb begin
      logic [IW-1:0]   ins;
      logic [DW-1:0]   a, b, res, ea;
      logic [39:0]     s40;
      logic [RA_W-1:0] d;
      logic [2:0]      op;
      logic [1:0]      c, sz;
      logic            s, go, wr, st;
      ins = '0; a = '0; b = '0; res = '0; ea = '0; s40 = '0;
      d = '0; op = '0; c = '0; sz = SZ_W; s = 1'b0;
      go = 1'b0; wr = 1'b0; st = 1'b0;
      we = '0;
      wa = '0;
      wd = '0;
      next_ctl      = ctl;
      next_dm_req   = '0;
      next_dm_we    = '0;
      next_dm_addr  = dm_addr;
      next_dm_wdata = dm_wdata;
      next_dm_be    = dm_be;
      next_ld1      = '0;
      for (int u = 0; u < 8; u++) begin
         ins = ui[u];
         s   = 1'(u >> 2);
         c   = 2'(u);
         d   = ins[DST_LO +: RA_W];
         op  = ins[OP_LO +: 3];
         a   = qf[s][ins[SRC1_LO +: RA_W]];
         b   = (ins[X_BIT] && c != CL_D) ? xbus[s]
             : qf[s][ins[SRC2_LO +: RA_W]];
         go  = uv[u] && pred_ok(ins[CREG_LO +: 3], ins[Z_BIT],
                                qf[0], qf[1]);
         wr  = go;
         res = '0;
         ea  = a + b;
         st  = (op == D_STW) || (op == D_STH) || (op == D_STB);
         sz  = (op == D_LDH || op == D_STH) ? SZ_H
             : (op == D_LDB || op == D_STB) ? SZ_B : SZ_W;
         s40 = 40'({{8{a[31]}}, a}) + 40'({{8{b[31]}}, b});
         case (c)
            CL_L: begin
               case (op)
                  L_ADD:   res = a + b;
                  L_SUB:   res = a - b;
                  L_AND:   res = a & b;
                  L_OR:    res = a | b;
                  L_XOR:   res = a ^ b;
                  L_ADD40: begin
                     res = s40[31:0];
                     we[s][WP_EXT] = go;
                     wa[s][WP_EXT] = d | 4'h1;
                     wd[s][WP_EXT] = {{24{s40[39]}}, s40[39:32]};
                  end
                  default: wr = 1'b0;
               endcase
            end
            CL_S: begin
               case (op)
                  S_SHL:      res = a << b[4:0];
                  S_SHR:      res = DW'($signed(a) >>> b[4:0]);
                  S_SHRU:     res = a >> b[4:0];
                  S_MVC_FROM: res = ctl[ins[SRC1_LO +: 2]];
                  S_MVC_TO: begin
                     wr = 1'b0;
                     if (go) begin
                        next_ctl[ins[DST_LO +: 2]] = b;
                     end
                  end
                  default: wr = 1'b0;
               endcase
            end
            CL_M: begin
               case (op)
                  M_MPY:   res = DW'($signed(a[15:0]) * $signed(b[15:0]));
                  M_MPYU:  res = DW'(a[15:0] * b[15:0]);
                  default: wr = 1'b0;
               endcase
            end
            default: begin
               if (op == D_ADD) begin
                  res = ea;
               end else if (op <= D_STB) begin
                  wr = 1'b0;
                  if (go) begin
                     next_dm_req[s]   = 1'b1;
                     next_dm_we[s]    = st;
                     next_dm_addr[s]  = {ea[31:2], 2'h0};
                     next_dm_be[s]    = mem_be(sz, ea[1:0]);
                     next_dm_wdata[s] = (sz == SZ_B) ? {4{qf[s][d][7:0]}}
                                      : (sz == SZ_H) ? {2{qf[s][d][15:0]}}
                                      : qf[s][d];
                     next_ld1[s]      = '{v: !st, dst: d, sz: sz,
                                          lane: ea[1:0]};
                  end
               end else begin
                  wr = 1'b0;
               end
            end
         endcase
         // Same-destination clashes are not resolved here
         we[s][c] = wr;
         wa[s][c] = d;
         wd[s][c] = res;
      end
      for (int k = 0; k < 2; k++) begin
         if (ld2[k].v) begin
            we[k][WP_LD] = 1'b1;
            wa[k][WP_LD] = ld2[k].dst;
            wd[k][WP_LD] = ld_extract(dm_rdata[k], ld2[k].sz, ld2[k].lane);
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         fs         <= FS_IDLE;
         pkt        <= '0;
         ptr        <= 3'h0;
         pc         <= PC_RESET;
         ctl        <= '0;
         dm_req     <= '0;
         dm_we      <= '0;
         dm_addr    <= '0;
         dm_wdata   <= '0;
         dm_be      <= '0;
         ld1        <= '0;
         ld2        <= '0;
         issue_mask <= '0;
      end else begin
         fs         <= next_fs;
         pkt        <= next_pkt;
         ptr        <= next_ptr;
         pc         <= next_pc;
         ctl        <= next_ctl;
         dm_req     <= next_dm_req;
         dm_we      <= next_dm_we;
         dm_addr    <= next_dm_addr;
         dm_wdata   <= next_dm_wdata;
         dm_be      <= next_dm_be;
         ld1        <= next_ld1;
         ld2        <= ld1;
         issue_mask <= ep_mask;
      end
   end

   assign fetch_addr = pc;

endmodule : vdp_core
`default_nettype wire

//--- shared/vdp_pkg.sv
`default_nettype none
package vdp_pkg;

   // Fetch and instruction geometry
   localparam int SLOTS     = 8;
   localparam int IW        = 32;
   localparam int FP_W      = 256;
   localparam int DW        = 32;
   localparam int NREG      = 16;
   localparam int RA_W      = 4;
   localparam int NCTL      = 4;
   localparam int NWP       = 6;
   localparam logic [31:0] PC_RESET   = 32'h0000_0000;
   localparam logic [31:0] FETCH_STEP = 32'h0000_0020;
   localparam logic [2:0]  LAST_SLOT  = 3'h7;

   // Instruction fields
   localparam int P_BIT   = 0;
   localparam int UNIT_LO = 1;
   localparam int OP_LO   = 4;
   localparam int X_BIT   = 7;
   localparam int SRC1_LO = 16;
   localparam int SRC2_LO = 20;
   localparam int DST_LO  = 24;
   localparam int Z_BIT   = 28;
   localparam int CREG_LO = 29;

   // Unit classes; unit field bit 2 picks the side
   localparam logic [1:0] CL_L = 2'h0;
   localparam logic [1:0] CL_S = 2'h1;
   localparam logic [1:0] CL_M = 2'h2;
   localparam logic [1:0] CL_D = 2'h3;

   // Write port indices; 0..3 follow the unit class
   localparam int WP_LD  = 4;
   localparam int WP_EXT = 5;

   // Opcodes per class
   localparam logic [2:0] L_ADD = 3'h0, L_SUB = 3'h1, L_AND = 3'h2;
   localparam logic [2:0] L_OR  = 3'h3, L_XOR = 3'h4, L_ADD40 = 3'h5;
   localparam logic [2:0] S_SHL = 3'h0, S_SHR = 3'h1, S_SHRU = 3'h2;
   localparam logic [2:0] S_MVC_TO = 3'h3, S_MVC_FROM = 3'h4;
   localparam logic [2:0] M_MPY = 3'h0, M_MPYU = 3'h1;
   localparam logic [2:0] D_LDW = 3'h0, D_LDH = 3'h1, D_LDB = 3'h2;
   localparam logic [2:0] D_STW = 3'h3, D_STH = 3'h4, D_STB = 3'h5;
   localparam logic [2:0] D_ADD = 3'h6;

   // Predicate selectors
   localparam logic [2:0] CR_NONE = 3'h0, CR_B0 = 3'h1, CR_B1 = 3'h2;
   localparam logic [2:0] CR_B2 = 3'h3, CR_A1 = 3'h4, CR_A2 = 3'h5;

   // Memory access sizes
   localparam logic [1:0] SZ_W = 2'h0, SZ_H = 2'h1, SZ_B = 2'h2;

   typedef enum logic {
      FS_IDLE = 1'b0,
      FS_HOLD = 1'b1
   } vdp_fst_t;

   typedef struct packed {
      logic            v;
      logic [RA_W-1:0] dst;
      logic [1:0]      sz;
      logic [1:0]      lane;
   } vdp_ld_t;

endpackage : vdp_pkg
`default_nettype wire

//--- shared/vdp_rf_if.sv
`timescale 1ns/1ps
`default_nettype none
interface vdp_rf_if;
   import vdp_pkg::*;
   logic [NWP-1:0]                we;
   logic [NWP-1:0][RA_W-1:0]      wa;
   logic [NWP-1:0][DW-1:0]        wd;
   logic [NREG-1:0][DW-1:0]       q;

   modport file (input we, input wa, input wd, output q);
   modport core (output we, output wa, output wd, input q);
endinterface : vdp_rf_if
`default_nettype wire

//--- hdl/vdp_regfile.sv
`timescale 1ns/1ps
`default_nettype none
module vdp_regfile
   import vdp_pkg::*;
(
   // Clock and reset
   input  wire logic mclk,
   input  wire logic rstn,
   // Core side
   vdp_rf_if.file    rf
);

   logic [NREG-1:0][DW-1:0] mem;
   logic [NREG-1:0][DW-1:0] next_mem;

   // Higher port index wins a same-entry clash; no arbitration by design
   always_comb begin
      next_mem = mem;
      for (int p = 0; p < NWP; p++) begin
         if (rf.we[p]) begin
            next_mem[rf.wa[p]] = rf.wd[p];
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         mem <= '0;
      end else begin
         mem <= next_mem;
      end
   end

   assign rf.q = mem;

endmodule : vdp_regfile
`default_nettype wire

//--- testbench/vdp_core_checker.sv
`timescale 1ns/1ps
`default_nettype none
module vdp_core_checker
   import vdp_pkg::*;
(
   // Clock and reset
   input wire logic             mclk,
   input wire logic             rstn,
   // Fetch
   input wire logic             fetch_req,
   input wire logic [31:0]      fetch_addr,
   input wire logic             fetch_valid,
   // Data memory and status
   input wire logic [1:0]       dm_req,
   input wire logic [1:0]       dm_we,
   input wire logic [1:0][31:0] dm_addr,
   input wire logic [1:0][31:0] dm_wdata,
   input wire logic [1:0][3:0]  dm_be,
   input wire logic [SLOTS-1:0] issue_mask
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rstn);

   a_fetch_step: assert property (
      rstn && fetch_req && fetch_valid |=>
      fetch_addr == $past(fetch_addr) + FETCH_STEP) else $error("bad step");
   a_fetch_hold: assert property (
      !(fetch_req && fetch_valid) |=> $stable(fetch_addr))
      else $error("fetch address moved without a take");
   a_chain_end: assert property (
      $rose(fetch_req) |=> issue_mask[SLOTS-1]) else $error("bad packet end");
   a_no_stall: assert property (
      $fell(fetch_req) |-> ##[1:7] fetch_req) else $error("dispatch stalled");
   a_issue_lat: assert property (
      rstn && fetch_req && fetch_valid |=> ##1 issue_mask != 8'h00)
      else $error("nothing issued after a take");
   a_mem_by_d: assert property (
      dm_req != 2'h0 |-> issue_mask != 8'h00) else $error("stray access");
   a_word_align: assert property (
      dm_req[0] |-> dm_addr[0][1:0] == 2'h0 && dm_be[0] != 4'h0)
      else $error("bad address or lanes");
   a_store_rep: assert property (
      dm_req[1] && dm_we[1] && dm_be[1] != 4'hf |->
      dm_wdata[1][31:16] == dm_wdata[1][15:0]) else $error("not replicated");
endmodule : vdp_core_checker

bind vdp_core vdp_core_checker u_chk (
   .mclk, .rstn, .fetch_req, .fetch_addr, .fetch_valid, .dm_req, .dm_we,
   .dm_addr, .dm_wdata, .dm_be, .issue_mask
);
`default_nettype wire

//--- testbench/vdp_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module vdp_mem_model
   import vdp_pkg::*;
#(
   parameter logic [31:0] W0 = 32'h0000_0004,
   parameter logic [31:0] W1 = 32'h8000_00f1
)
(
   // Clock
   input  wire logic                  mclk,
   // Program memory
   input  wire logic [31:0]           fetch_addr,
   output logic                       fetch_valid,
   output logic [FP_W-1:0]            fetch_packet,
   // Data memory
   input  wire logic [1:0]            dm_req,
   input  wire logic [1:0]            dm_we,
   input  wire logic [1:0][31:0]      dm_addr,
   input  wire logic [1:0][31:0]      dm_wdata,
   input  wire logic [1:0][3:0]       dm_be,
   output logic [1:0][31:0]           dm_rdata
);
   logic [FP_W-1:0] prog [32];
   logic [31:0]     mem [64];
   logic            slow = 1'b0;
   logic            tick = 1'b0;

   // Never-execute filler keeps unused slots harmless
   task automatic clear;
      for (int i = 0; i < 32; i++)
         prog[i] = {SLOTS{32'he000_0000}};
      for (int i = 0; i < 64; i++)
         mem[i] = 32'hffff_ffff;
      mem[0] = W0;
      mem[1] = W1;
   endtask : clear

   // Slow mode offers a packet only every other cycle
   assign fetch_valid = !slow || tick;
   assign fetch_packet = fetch_valid ? prog[fetch_addr[9:5]]
                                     : ~prog[fetch_addr[9:5]];

   initial dm_rdata = '0;

   // Read data lives one cycle only, then scrambles
   always @(posedge mclk) begin
      tick <= !tick;
      for (int i = 0; i < 2; i++) begin
         if (dm_req[i] && !dm_we[i])
            dm_rdata[i] <= mem[dm_addr[i][7:2]];
         else
            dm_rdata[i] <= ~dm_rdata[i];
         for (int b = 0; b < 4; b++)
            if (dm_req[i] && dm_we[i] && dm_be[i][b])
               mem[dm_addr[i][7:2]][8*b +: 8] <= dm_wdata[i][8*b +: 8];
      end
   end
endmodule : vdp_mem_model
`default_nettype wire

//--- testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb
   import vdp_pkg::*;
;
   localparam logic [31:0] W0 = 32'h0000_0004;
   localparam logic [31:0] W1 = 32'h8000_00f1;
   localparam logic [2:0]  LA = {1'b0, CL_L};
   localparam logic [2:0]  SA = {1'b0, CL_S};
   localparam logic [2:0]  MA = {1'b0, CL_M};
   localparam logic [2:0]  DA = {1'b0, CL_D};
   localparam logic [2:0]  LB = {1'b1, CL_L};
   localparam logic [2:0]  SB = {1'b1, CL_S};
   localparam logic [2:0]  DB = {1'b1, CL_D};
   // Sum of the sign-extended W1 with itself, as a 40-bit add gives it
   localparam logic [39:0] S40 = {{8{W1[31]}}, W1} + {{8{W1[31]}}, W1};

   logic                   mclk;
   logic                   rstn;
   logic                   fetch_req;
   logic [31:0]            fetch_addr;
   logic                   fetch_valid;
   logic [FP_W-1:0]        fetch_packet;
   logic [1:0]             dm_req;
   logic [1:0]             dm_we;
   logic [1:0][31:0]       dm_addr;
   logic [1:0][31:0]       dm_wdata;
   logic [1:0][3:0]        dm_be;
   logic [1:0][31:0]       dm_rdata;
   logic [SLOTS-1:0]       issue_mask;
   int                     n_errors = 0;
   int                     checks_done = 0;
   int                     cycles = 0;

   vdp_core u_vdp_core (
      .mclk, .rstn, .fetch_req, .fetch_addr, .fetch_valid, .fetch_packet,
      .dm_req, .dm_we, .dm_addr, .dm_wdata, .dm_be, .dm_rdata, .issue_mask
   );
   vdp_mem_model #(.W0(W0), .W1(W1)) u_mem (
      .mclk, .fetch_addr, .fetch_valid, .fetch_packet,
      .dm_req, .dm_we, .dm_addr, .dm_wdata, .dm_be, .dm_rdata
   );

   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end

   // Programs need about 370 cycles; generous ceiling
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         n_errors++;
         final_report();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH %0t got %h want %h", $time, got, exp);
      end
   endtask : chk

   task automatic final_report;
      $display("errors %0d checks %0d", n_errors, checks_done);
      if (n_errors == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : final_report

   function automatic logic [31:0] ins(input int c, input logic [2:0] u,
      input logic [2:0] o, input int s1, input int s2, input int d,
      input int x = 0, input logic [2:0] cr = CR_NONE);
      return {cr, 1'b0, 4'(d), 4'(s2), 4'(s1), 8'h00, x[0], o, u, c[0]};
   endfunction : ins

   task automatic put(input int k, input int s, input logic [31:0] w);
      u_mem.prog[k][32*s +: 32] = w;
   endtask : put

   // Program loads under reset so the old one cannot store meanwhile
   task automatic hold;
      @(posedge mclk);
      #1 rstn = 1'b0;
      u_mem.clear();
   endtask : hold

   task automatic go(input int n);
      repeat (4) @(posedge mclk);
      #1;
      chk(fetch_addr, PC_RESET);
      chk(32'(issue_mask), 32'h0);
      rstn = 1'b1;
      repeat (n) @(posedge mclk);
      #1;
   endtask : go

   task automatic s_arith;
      hold();
      put(0, 0, ins(0, DA, D_LDW, 0, 0, 1));
      put(1, 0, ins(0, DA, D_LDW, 1, 0, 3));
      put(2, 0, ins(0, LA, L_ADD, 3, 1, 5));
      put(3, 0, ins(0, SA, S_SHL, 1, 1, 6));
      put(4, 0, ins(0, MA, M_MPY, 3, 1, 7));
      put(5, 0, ins(0, DA, D_STW, 1, 1, 5));
      put(6, 0, ins(0, DA, D_ADD, 1, 1, 8));
      put(7, 0, ins(0, DA, D_STW, 8, 1, 6));
      put(8, 0, ins(0, DA, D_STW, 8, 8, 7));
      put(9, 0, ins(0, DA, D_LDB, 1, 0, 9));
      put(10, 0, ins(0, DA, D_STW, 8, 6, 9));
      go(100);
      chk(u_mem.mem[2], W1 + W0);
      chk(u_mem.mem[3], W0 << W0);
      chk(u_mem.mem[4], W0 * {16'h0, W1[15:0]});
      chk(u_mem.mem[18], {{24{W1[7]}}, W1[7:0]});
   endtask : s_arith

   task automatic s_cross;
      hold();
      u_mem.slow = 1'b1;
      put(0, 0, ins(1, DA, D_LDW, 0, 0, 1));
      put(0, 1, ins(0, DB, D_LDW, 0, 0, 1));
      put(1, 0, ins(0, DB, D_LDW, 1, 0, 2));
      put(2, 0, ins(1, LA, L_ADD, 1, 2, 2, 1));
      put(2, 1, ins(1, LB, L_SUB, 2, 1, 3));
      put(2, 2, ins(1, SA, S_SHL, 1, 1, 9, 0, CR_B0));
      put(2, 3, ins(0, MA, M_MPYU, 1, 1, 10, 0, CR_A1));
      put(3, 0, ins(1, DA, D_STW, 1, 1, 2));
      put(3, 1, ins(0, DB, D_STB, 1, 0, 3));
      put(4, 0, ins(0, SA, S_MVC_TO, 0, 10, 2));
      put(5, 0, ins(0, SB, S_MVC_FROM, 2, 0, 5));
      put(6, 0, ins(1, DA, D_STW, 10, 10, 9));
      put(6, 1, ins(0, DB, D_STW, 5, 1, 5));
      go(130);
      chk(u_mem.mem[2], W1 + W0);
      chk(u_mem.mem[1], {W1[31:8], 8'(W1 - W0)});
      chk(u_mem.mem[8], 32'h0);
      chk(u_mem.mem[5], W0 * W0);
   endtask : s_cross

   task automatic s_nostall;
      hold();
      u_mem.slow = 1'b0;
      put(0, 0, ins(0, DA, D_LDW, 0, 0, 1));
      put(0, 1, ins(0, LA, L_ADD, 1, 1, 2));
      put(0, 3, ins(0, LA, L_ADD, 1, 1, 3));
      put(0, 4, ins(0, DA, D_STW, 1, 1, 2));
      put(0, 5, ins(0, DA, D_STW, 3, 1, 3));
      // All eight units in one execute packet
      for (int s = 0; s < 8; s++) begin
         put(1, s, ins(s < 7, 3'(s), (s % 4 == 3) ? D_ADD : 3'h0,
                       1, 1, 4 + s));
      end
      go(0);
      for (int n = 0; n < 20 && issue_mask !== 8'h80; n++) begin
         @(posedge mclk);
         #1;
      end
      @(posedge mclk);
      #1;
      chk(32'(issue_mask), 32'h0000_00ff);
      @(posedge mclk);
      #1;
      chk(32'(issue_mask), 32'h0000_0001);
      repeat (20) @(posedge mclk);
      chk(u_mem.mem[2], 32'h0);
      chk(u_mem.mem[3], W0 + W0);
   endtask : s_nostall

   task automatic s_ext;
      hold();
      u_mem.slow = 1'b0;
      put(0, 0, ins(0, DA, D_LDW, 0, 0, 1));
      put(1, 0, ins(0, DA, D_LDW, 1, 0, 3));
      put(2, 0, ins(1, LA, L_ADD40, 3, 3, 4));
      put(2, 1, ins(0, DA, D_ADD, 1, 1, 8));
      // Negative W1 leaves minus one high, so minus two reaches lane 2
      put(3, 0, ins(0, LA, L_ADD, 5, 5, 6));
      put(4, 0, ins(0, DA, D_LDH, 8, 6, 10));
      put(5, 0, ins(0, DA, D_STH, 8, 6, 3));
      put(6, 0, ins(0, DA, D_STW, 1, 1, 4));
      put(7, 0, ins(0, DA, D_STW, 8, 1, 5));
      put(8, 0, ins(0, DA, D_STW, 8, 8, 10));
      go(90);
      chk(u_mem.mem[2], S40[31:0]);
      chk(u_mem.mem[3], {{24{S40[39]}}, S40[39:32]});
      chk(u_mem.mem[4], {{16{W1[31]}}, W1[31:16]});
      chk(u_mem.mem[1], {2{W1[15:0]}});
   endtask : s_ext

   initial begin
      rstn = 1'b0;
      s_arith();
      s_cross();
      s_nostall();
      s_ext();
      final_report();
   end
endmodule : tb
`default_nettype wire
